//--- rtl/reloadable_dma_channel.sv
`timescale 1ns/1ps
`include "dma_chan_params.svh"
// What this block does
// RULE1 - clock gated while module stop bit set
// RULE2 - disabled channel performs no transfers
// RULE3 - setting enable starts servicing requests
// RULE4 - single mode: one transfer per request
// RULE5 - source reload bit reloads source and count
// RULE6 - destination reload bit reloads destination and count
// RULE7 - masked end flag keeps channel running
// RULE8 - destination address increments, decrements or fixed
// RULE9 - source address increments, decrements or fixed
// RULE10 - source code 1000 selects extension selector
// RULE11 - software picks cycle steal in single mode
// RULE12 - size field sets width and step
// RULE13 - interrupt enable gates end interrupt
// RULE14 - selector routes peripheral request to channel
// RULE15 - address error cleared by read then zero
// RULE16 - nmi flag cleared by read then zero
// RULE17 - master enable gates every channel
// RULE18 - software follows the setup order
// RULE19 - reload count register feeds count reload
// RULE20 - reload source register feeds source reload
// RULE21 - reload destination register feeds destination reload
// RULE22 - unmasked end disables channel, sets flag
// RULE23 - at zero, reload same cycle and continue
module reloadable_dma_channel
(
    input  wire logic                   clk_i,
    input  wire logic                   rst_n_i,
    input  wire logic                   psel_i,
    input  wire logic                   penable_i,
    input  wire logic                   pwrite_i,
    input  wire logic [11:0]            paddr_i,
    input  wire logic [31:0]            pwdata_i,
    output      logic [31:0]            prdata_o,
    output      logic                   pready_o,
    output      logic                   pslverr_o,
    input  wire logic [7:0]             per_req_i,
    input  wire logic                   nmi_i,
    output      logic                   mem_req_o,
    output      logic [31:0]            mem_addr_o,
    output      logic [1:0]             mem_size_o,
    input  wire logic                   mem_ack_i,
    input  wire logic                   mem_err_i,
    input  wire logic [31:0]            mem_rdata_i,
    output      logic                   per_valid_o,
    output      dma_chan_pkg::per_beat_t per_beat_o,
    input  wire logic                   per_ready_i,
    output      logic                   end_irq_o
);
    import dma_chan_pkg::*;

    eng_state_t  state_r;
    chan_ctrl_t  ctrl_r;
    logic [31:0] src_r;
    logic [31:0] dst_r;
    logic [31:0] cnt_r;
    logic [31:0] src_rld_r;
    logic [31:0] dst_rld_r;
    logic [31:0] cnt_rld_r;
    logic [7:0]  reqsel_r;
    logic [7:0]  standby_r;
    logic        men_r;
    logic        ae_r;
    logic        nmi_r;
    logic        ae_seen_r;
    logic        nmi_seen_r;
    logic        req_prev_r;
    logic        pend_r;
    logic [31:0] prdata_r;
    per_beat_t   beat_r;

    logic        acc_w;
    logic        acc_r;
    logic        mapped;
    logic        mstop;
    logic        sel_req;
    logic        req_edge;
    logic        go;
    logic        misalign;
    logic        start;
    logic        done;
    logic        last;
    logic        rld_any;
    logic [31:0] step;
    logic [31:0] rd_mux;
    logic [31:0] src_nxt;
    logic [31:0] dst_nxt;

    assign acc_w = psel_i && penable_i && pwrite_i;
    assign acc_r = psel_i && penable_i && !pwrite_i;
    assign mstop = standby_r[`BIT_MSTOP];

    always_comb begin
        mapped = 1'b1;
        rd_mux = 32'h0000_0000;
        case (paddr_i)
            `OFS_SRC_ADDR:   rd_mux = src_r;
            `OFS_DST_ADDR:   rd_mux = dst_r;
            `OFS_COUNT:      rd_mux = cnt_r;
            `OFS_CHAN_CTRL:  rd_mux = {1'b0, ctrl_r[17:15], 5'h00, ctrl_r[14], 6'h00, ctrl_r[13:6], 2'h0, ctrl_r[5:0]};
            `OFS_SRC_RELOAD: rd_mux = src_rld_r;
            `OFS_DST_RELOAD: rd_mux = dst_rld_r;
            `OFS_CNT_RELOAD: rd_mux = cnt_rld_r;
            `OFS_OPERATION:  rd_mux = {29'h0000_0000, ae_r, nmi_r, men_r};
            `OFS_EXT_REQSEL: rd_mux = {24'h00_0000, reqsel_r};
            `OFS_STANDBY:    rd_mux = {24'h00_0000, standby_r};
            default:         mapped = 1'b0;
        endcase
    end

    // Zero wait states; read data is latched in the setup cycle
    assign pready_o  = 1'b1;
    assign pslverr_o = psel_i && penable_i && !mapped;
    assign prdata_o  = prdata_r;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            prdata_r <= 32'h0000_0000;
        end else if (psel_i && !penable_i && !pwrite_i) begin
            prdata_r <= rd_mux;
        end
    end

    // RULE14 RULE10 request routing
    assign sel_req  = (ctrl_r.rs == `RS_EXT_SEL) && per_req_i[reqsel_r[2:0]];
    assign req_edge = sel_req && !req_prev_r;

    // RULE1 RULE2 RULE17 transfer gate
    assign go = !mstop && men_r && ctrl_r.en && !ae_r && !nmi_r && (cnt_r != 32'h0000_0000);

    // RULE12 step by transfer width
    always_comb begin
        case (ctrl_r.ts)
            `SZ_BYTE: step = 32'h0000_0001;
            `SZ_WORD: step = 32'h0000_0002;
            default:  step = 32'h0000_0004;
        endcase
    end

    always_comb begin
        case (ctrl_r.ts)
            `SZ_BYTE: misalign = 1'b0;
            `SZ_WORD: misalign = src_r[0] || dst_r[0];
            default:  misalign = (src_r[1:0] != 2'h0) || (dst_r[1:0] != 2'h0);
        endcase
    end

    // RULE9 source step mode
    always_comb begin
        case (ctrl_r.sm)
            `AM_INC: src_nxt = src_r + step;
            `AM_DEC: src_nxt = src_r - step;
            default: src_nxt = src_r;
        endcase
    end

    // RULE8 destination step mode
    always_comb begin
        case (ctrl_r.dm)
            `AM_INC: dst_nxt = dst_r + step;
            `AM_DEC: dst_nxt = dst_r - step;
            default: dst_nxt = dst_r;
        endcase
    end

    assign start   = (state_r == ST_IDLE) && go && pend_r && !misalign;
    assign done    = (state_r == ST_WRITE) && per_ready_i && !mstop;
    assign last    = done && (cnt_r == 32'h0000_0001);
    assign rld_any = ctrl_r.src_rld || ctrl_r.dst_rld;

    // RULE1 engine frozen while module stopped
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state_r <= ST_IDLE;
        end else if (!mstop) begin
            case (state_r)
                ST_IDLE:  if (start) state_r <= ST_READ;
                ST_READ:  if (mem_ack_i) state_r <= mem_err_i ? ST_IDLE : ST_WRITE;
                ST_WRITE: if (per_ready_i) state_r <= ST_IDLE;
                default:  state_r <= ST_IDLE;
            endcase
        end
    end

    assign mem_req_o   = (state_r == ST_READ) && !mstop;
    assign mem_addr_o  = src_r;
    assign mem_size_o  = ctrl_r.ts;
    assign per_valid_o = (state_r == ST_WRITE) && !mstop;
    assign per_beat_o  = beat_r;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            beat_r <= '0;
        end else if (state_r == ST_READ && mem_ack_i && !mstop) begin
            beat_r <= '{addr: dst_r, data: mem_rdata_i, size: ctrl_r.ts};
        end
    end

    // Pending request; in block mode one request covers the whole count
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            req_prev_r <= 1'b0;
            pend_r     <= 1'b0;
        end else if (!mstop) begin
            req_prev_r <= sel_req;
            if (req_edge && ctrl_r.en) begin
                pend_r <= 1'b1;
            // RULE4 one transfer per request
            end else if (done && (!ctrl_r.single_n || last)) begin
                pend_r <= 1'b0;
            end else if (!ctrl_r.en) begin
                pend_r <= 1'b0;
            end
        end
    end

    // Address and count registers
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            src_r <= 32'h0000_0000;
            dst_r <= 32'h0000_0000;
            cnt_r <= 32'h0000_0000;
        end else if (last && rld_any) begin
            // RULE23 RULE5 RULE6 reload in the same cycle
            // A side that is not reloaded keeps stepping in its own mode
            // RULE20 source reload
            src_r <= ctrl_r.src_rld ? src_rld_r : src_nxt;
            // RULE21 destination reload
            dst_r <= ctrl_r.dst_rld ? dst_rld_r : dst_nxt;
            // RULE19 count reload
            cnt_r <= cnt_rld_r;
        end else if (done) begin
            src_r <= src_nxt;
            dst_r <= dst_nxt;
            cnt_r <= cnt_r - 32'h0000_0001;
        end else if (acc_w) begin
            if (paddr_i == `OFS_SRC_ADDR) src_r <= pwdata_i;
            if (paddr_i == `OFS_DST_ADDR) dst_r <= pwdata_i;
            if (paddr_i == `OFS_COUNT)    cnt_r <= pwdata_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            src_rld_r <= 32'h0000_0000;
            dst_rld_r <= 32'h0000_0000;
            cnt_rld_r <= 32'h0000_0000;
            reqsel_r  <= 8'h00;
            standby_r <= `RST_STANDBY;
        end else if (acc_w) begin
            if (paddr_i == `OFS_SRC_RELOAD) src_rld_r <= pwdata_i;
            if (paddr_i == `OFS_DST_RELOAD) dst_rld_r <= pwdata_i;
            if (paddr_i == `OFS_CNT_RELOAD) cnt_rld_r <= pwdata_i;
            if (paddr_i == `OFS_EXT_REQSEL) reqsel_r  <= pwdata_i[7:0];
            if (paddr_i == `OFS_STANDBY)    standby_r <= pwdata_i[7:0];
        end
    end

    // Channel control; hardware end events win over a software write
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ctrl_r <= '0;
        end else begin
            if (acc_w && paddr_i == `OFS_CHAN_CTRL) begin
                // RULE3 enable written by software
                ctrl_r <= chan_ctrl_t'({pwdata_i[30:28], pwdata_i[22], pwdata_i[15:8], pwdata_i[5:0]});
            end
            if (last) begin
                ctrl_r.te <= 1'b1;
                // RULE22 RULE7 stop only when end flag unmasked
                if (!ctrl_r.emask) ctrl_r.en <= 1'b0;
            end
        end
    end

    // RULE13 end interrupt
    assign end_irq_o = ctrl_r.te && ctrl_r.ie;

    // Operation register flags; clear needs a prior read of one
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            men_r      <= 1'b0;
            ae_r       <= 1'b0;
            nmi_r      <= 1'b0;
            ae_seen_r  <= 1'b0;
            nmi_seen_r <= 1'b0;
        end else begin
            if (acc_w && paddr_i == `OFS_OPERATION) men_r <= pwdata_i[`BIT_MASTER_EN];
            // RULE15 address error flag
            if ((start == 1'b0 && state_r == ST_IDLE && go && pend_r && misalign) ||
                (state_r == ST_READ && mem_ack_i && mem_err_i && !mstop)) begin
                ae_r <= 1'b1;
            end else if (acc_w && paddr_i == `OFS_OPERATION && !pwdata_i[`BIT_AE] && ae_seen_r) begin
                ae_r      <= 1'b0;
                ae_seen_r <= 1'b0;
            end else if (acc_r && paddr_i == `OFS_OPERATION && ae_r) begin
                ae_seen_r <= 1'b1;
            end
            // RULE16 nmi flag
            if (nmi_i) begin
                nmi_r <= 1'b1;
            end else if (acc_w && paddr_i == `OFS_OPERATION && !pwdata_i[`BIT_NMI] && nmi_seen_r) begin
                nmi_r      <= 1'b0;
                nmi_seen_r <= 1'b0;
            end else if (acc_r && paddr_i == `OFS_OPERATION && nmi_r) begin
                nmi_seen_r <= 1'b1;
            end
        end
    end

    stop_freezes_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE1
        mstop && state_r == ST_IDLE |=> state_r == ST_IDLE)
        else $error("engine left idle while stopped");

    disabled_idle_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE2
        state_r == ST_IDLE && !ctrl_r.en |=> state_r == ST_IDLE)
        else $error("disabled channel started");

    master_gate_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE17
        state_r == ST_IDLE && !men_r |=> state_r != ST_READ)
        else $error("transfer without master enable");

    source_sel_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE10
        $rose(state_r == ST_READ) |-> $past(ctrl_r.rs) == `RS_EXT_SEL)
        else $error("transfer with wrong request source");

    single_req_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE4
        done && !ctrl_r.single_n && !(req_edge && ctrl_r.en) |=> !pend_r)
        else $error("request not consumed");

    reload_copy_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE23
        last && rld_any |=> cnt_r == $past(cnt_rld_r) && state_r == ST_IDLE)
        else $error("count not reloaded");

    end_stop_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE22
        last && !ctrl_r.emask |=> !ctrl_r.en && ctrl_r.te)
        else $error("unmasked end did not stop channel");

    mask_run_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE7
        last && ctrl_r.emask && !acc_w |=> ctrl_r.en && ctrl_r.te)
        else $error("masked end stopped channel");

    fixed_dst_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE8
        done && ctrl_r.dm == `AM_FIXED && !ctrl_r.dst_rld |=> $stable(dst_r))
        else $error("fixed destination moved");

    src_step_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE12
        done && !last && ctrl_r.sm == `AM_INC |=> src_r == $past(src_r) + $past(step))
        else $error("source step wrong");

    ae_read_first_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE15
        ae_r && !ae_seen_r |=> ae_r)
        else $error("address error cleared without read");

    irq_gate_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE13
        last && ctrl_r.ie |=> end_irq_o)
        else $error("end interrupt missing");

    src_reload_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE20
        last && ctrl_r.src_rld |=> src_r == $past(src_rld_r))
        else $error("source not reloaded");

    dst_reload_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE21
        last && ctrl_r.dst_rld |=> dst_r == $past(dst_rld_r))
        else $error("destination not reloaded");

    nmi_read_first_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE16
        nmi_r && !nmi_seen_r |=> nmi_r)
        else $error("nmi flag cleared without read");

    enable_start_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE3
        start |=> state_r == ST_READ)
        else $error("enabled channel did not start");
endmodule

//--- rtl/dma_chan_params.svh
`ifndef DMA_CHAN_PARAMS_SVH
`define DMA_CHAN_PARAMS_SVH
`define OFS_SRC_ADDR   12'h000
`define OFS_DST_ADDR   12'h004
`define OFS_COUNT      12'h008
`define OFS_CHAN_CTRL  12'h00C
`define OFS_SRC_RELOAD 12'h010
`define OFS_DST_RELOAD 12'h014
`define OFS_CNT_RELOAD 12'h018
`define OFS_OPERATION  12'h020
`define OFS_EXT_REQSEL 12'h024
`define OFS_STANDBY    12'h028
`define BIT_CH_EN      0
`define BIT_TE         1
`define BIT_IE         2
`define BIT_TB         5
`define BIT_EMASK      22
`define BIT_DST_RLD    28
`define BIT_SINGLE     29
`define BIT_SRC_RLD    30
`define BIT_MASTER_EN  0
`define BIT_NMI        1
`define BIT_AE         2
`define BIT_MSTOP      0
`define RST_STANDBY    8'h01
`define RS_EXT_SEL     4'h8
`define AM_FIXED       2'h0
`define AM_INC         2'h1
`define AM_DEC         2'h2
`define SZ_BYTE        2'h0
`define SZ_WORD        2'h1
`endif

//--- rtl/dma_chan_pkg.sv
package dma_chan_pkg;
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_READ  = 3'b010,
        ST_WRITE = 3'b100
    } eng_state_t;

    typedef struct packed {
        logic       src_rld;
        logic       single_n;
        logic       dst_rld;
        logic       emask;
        logic [1:0] dm;
        logic [1:0] sm;
        logic [3:0] rs;
        logic       tb;
        logic [1:0] ts;
        logic       ie;
        logic       te;
        logic       en;
    } chan_ctrl_t;

    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] data;
        logic [1:0]  size;
    } per_beat_t;
endpackage

//--- tb/audio_peer_model.sv
`timescale 1ns/1ps
module audio_peer_model (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        fire_i,
    input  wire logic        slow_i,
    input  wire logic        mem_req_i,
    input  wire logic [31:0] mem_addr_i,
    input  wire logic        per_valid_i,
    output      logic [7:0]  per_req_o,
    output      logic        mem_ack_o,
    output      logic [31:0] mem_rdata_o,
    output      logic        per_ready_o
);
    logic [1:0] req_r;
    logic [1:0] wait_r;

    assign per_req_o = {4'h0, req_r[0] | req_r[1], 3'h0};

    // Two-cycle level so the edge detector always sees it
    always_ff @(posedge clk_i) begin
        req_r <= rst_n_i ? {req_r[0], fire_i} : 2'h0;
    end

    // Read data toggles outside the ack cycle so stale data never looks valid
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            wait_r      <= 2'h0;
            mem_ack_o   <= 1'b0;
            mem_rdata_o <= 32'h0;
        end else if (mem_req_i && !mem_ack_o && wait_r == 2'h0) begin
            mem_ack_o   <= 1'b1;
            mem_rdata_o <= mem_addr_i ^ 32'hA5A5_0000;
        end else begin
            mem_ack_o   <= 1'b0;
            mem_rdata_o <= ~mem_rdata_o;
            wait_r      <= (mem_req_i && !mem_ack_o) ? wait_r - 2'h1 : (slow_i ? 2'h2 : 2'h0);
        end
    end

    assign per_ready_o = per_valid_i;
endmodule

//--- tb/testbench.sv
`timescale 1ns/1ps
`include "dma_chan_params.svh"
`define CHECK_EQ(g, e) check_eq(32'(g), 32'(e))
module testbench;
    import dma_chan_pkg::*;
    logic        clk_i, rst_n_i, psel, penable, pwrite, nmi, fire, slow, err, busy;
    logic        pready, pslverr, mem_req, mem_ack, per_valid, per_ready, end_irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, mem_addr, mem_rdata, rd;
    logic [1:0]  mem_size;
    logic [7:0]  per_req;
    per_beat_t   beat;
    int          mismatches, n_checks;

    reloadable_dma_channel i_dut (
        .clk_i       (clk_i),
        .rst_n_i     (rst_n_i),
        .psel_i      (psel),
        .penable_i   (penable),
        .pwrite_i    (pwrite),
        .paddr_i     (paddr),
        .pwdata_i    (pwdata),
        .prdata_o    (prdata),
        .pready_o    (pready),
        .pslverr_o   (pslverr),
        .per_req_i   (per_req),
        .nmi_i       (nmi),
        .mem_req_o   (mem_req),
        .mem_addr_o  (mem_addr),
        .mem_size_o  (mem_size),
        .mem_ack_i   (mem_ack),
        .mem_err_i   (1'b0),
        .mem_rdata_i (mem_rdata),
        .per_valid_o (per_valid),
        .per_beat_o  (beat),
        .per_ready_i (per_ready),
        .end_irq_o   (end_irq)
    );

    audio_peer_model i_peer (
        .clk_i       (clk_i),
        .rst_n_i     (rst_n_i),
        .fire_i      (fire),
        .slow_i      (slow),
        .mem_req_i   (mem_req),
        .mem_addr_i  (mem_addr),
        .per_valid_i (per_valid),
        .per_req_o   (per_req),
        .mem_ack_o   (mem_ack),
        .mem_rdata_o (mem_rdata),
        .per_ready_o (per_ready)
    );

    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    task automatic check_eq(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic stop_test();
        $display("checks=%0d mismatches=%0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Only the watchdog ends a wait on pready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        @(posedge clk_i);
        while (pready !== 1'b1)
            @(posedge clk_i);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        check_eq(rd, e);
    endtask

    task automatic req();
        @(posedge clk_i);
        fire <= 1'b1;
        @(posedge clk_i);
        fire <= 1'b0;
    endtask

    task automatic quiet();
        busy = 1'b0;
        repeat (20) begin
            @(posedge clk_i);
            if (mem_req === 1'b1 || per_valid === 1'b1)
                busy = 1'b1;
        end
    endtask

    task automatic beat_chk(input logic [31:0] s, input logic [31:0] d, input logic [1:0] z);
        int i;
        req();
        for (i = 0; i < 100; i++) begin
            @(posedge clk_i);
            if (per_valid === 1'b1 && per_ready === 1'b1)
                break;
        end
        check_eq(beat.addr, d);
        check_eq(beat.data, s ^ 32'hA5A5_0000);
        check_eq(32'(beat.size), 32'(z));
    endtask

    // source 1000, cycle steal, one transfer per request
    function automatic logic [31:0] mode(input logic [1:0] sz, sm, dm, input logic mask, srl, drl);
        return {1'b0, srl, 1'b0, drl, 5'h0, mask, 6'h0, dm, sm, 4'h8, 3'h0, sz, 1'b1, 2'h0};
    endfunction

    task automatic cfg(input logic [31:0] s, d, n, rs, rdst, rn, m);
        wr(`OFS_STANDBY, 32'h0);
        wr(`OFS_CHAN_CTRL, 32'h0);
        wr(`OFS_SRC_ADDR, s);
        wr(`OFS_SRC_RELOAD, rs);
        wr(`OFS_DST_ADDR, d);
        wr(`OFS_DST_RELOAD, rdst);
        wr(`OFS_COUNT, n);
        wr(`OFS_CNT_RELOAD, rn);
        wr(`OFS_CHAN_CTRL, m);
        wr(`OFS_EXT_REQSEL, 32'h3);
        apb(1'b0, `OFS_OPERATION, 32'h0);
        wr(`OFS_OPERATION, 32'h1);
        wr(`OFS_CHAN_CTRL, m | 32'h1);
    endtask

    task automatic t_regs();
        rdchk(`OFS_STANDBY, 32'h1);
        rdchk(`OFS_OPERATION, 32'h0);
        wr(`OFS_CNT_RELOAD, 32'hA5);
        rdchk(`OFS_CNT_RELOAD, 32'hA5);
        wr(12'h01C, 32'hFFFF_FFFF);
        `CHECK_EQ(err, 1);
        rdchk(12'h01C, 32'h0);
    endtask

    task automatic t_single();
        cfg(32'h100, 32'hC008, 32'h3, 32'h0, 32'h0, 32'h0, mode(2'h2, `AM_INC, `AM_FIXED, 0, 0, 0));
        for (int i = 0; i < 3; i++) begin
            beat_chk(32'h100 + 4 * i, 32'hC008, 2'h2);
            quiet();
            `CHECK_EQ(busy, 0);
        end
        apb(1'b0, `OFS_CHAN_CTRL, 32'h0);
        `CHECK_EQ(rd[1:0], 2'h2);
        `CHECK_EQ(end_irq, 1);
        // Nonzero count, so only the cleared enable holds it off
        wr(`OFS_COUNT, 32'h1);
        req();
        quiet();
        `CHECK_EQ(busy, 0);
    endtask

    task automatic t_reload();
        slow <= 1'b1;
        cfg(32'h200, 32'h300, 32'h2, 32'h400, 32'h500, 32'h2, mode(2'h1, `AM_DEC, `AM_INC, 1, 1, 1));
        beat_chk(32'h200, 32'h300, 2'h1);
        beat_chk(32'h1FE, 32'h302, 2'h1);
        beat_chk(32'h400, 32'h500, 2'h1);
        rdchk(`OFS_COUNT, 32'h1);
        apb(1'b0, `OFS_CHAN_CTRL, 32'h0);
        `CHECK_EQ(rd[0], 1);
        `CHECK_EQ(rd, mode(2'h1, `AM_DEC, `AM_INC, 1, 1, 1) | 32'h3);
        cfg(32'h210, 32'h310, 32'h1, 32'h0, 32'h520, 32'h1, mode(2'h1, `AM_DEC, `AM_INC, 1, 0, 1));
        beat_chk(32'h210, 32'h310, 2'h1);
        beat_chk(32'h20E, 32'h520, 2'h1);
        slow <= 1'b0;
    endtask

    task automatic t_flags();
        @(posedge clk_i);
        nmi <= 1'b1;
        @(posedge clk_i);
        nmi <= 1'b0;
        wr(`OFS_OPERATION, 32'h0);
        rdchk(`OFS_OPERATION, 32'h2);
        wr(`OFS_OPERATION, 32'h0);
        rdchk(`OFS_OPERATION, 32'h0);
        cfg(32'h101, 32'hC008, 32'h1, 32'h0, 32'h0, 32'h0, mode(2'h2, `AM_INC, `AM_FIXED, 0, 0, 0));
        req();
        quiet();
        `CHECK_EQ(busy, 0);
        wr(`OFS_OPERATION, 32'h1);
        rdchk(`OFS_OPERATION, 32'h5);
        // Drop the misaligned request first, or it raises the flag again
        wr(`OFS_CHAN_CTRL, 32'h0);
        wr(`OFS_OPERATION, 32'h1);
        rdchk(`OFS_OPERATION, 32'h1);
    endtask

    task automatic t_gates();
        cfg(32'h600, 32'hC008, 32'h2, 32'h0, 32'h0, 32'h0, mode(2'h2, `AM_INC, `AM_FIXED, 0, 0, 0));
        wr(`OFS_OPERATION, 32'h0);
        req();
        quiet();
        `CHECK_EQ(busy, 0);
        wr(`OFS_STANDBY, 32'h1);
        wr(`OFS_OPERATION, 32'h1);
        req();
        quiet();
        `CHECK_EQ(busy, 0);
    endtask

    initial begin
        #100000;
        mismatches++;
        stop_test();
    end

    initial begin
        {rst_n_i, psel, penable, pwrite, nmi, fire, slow} = 7'h0;
        paddr = 12'h0;
        pwdata = 32'h0;
        mismatches = 0;
        n_checks = 0;
        repeat (6) @(posedge clk_i);
        rst_n_i <= 1'b1;
        t_regs();
        t_single();
        t_reload();
        t_flags();
        t_gates();
        stop_test();
    end
endmodule
